// [pkg/usart_pkg.sv]
// constants for the serial clock generator and receive buffering block
// assumes a 32-bit AXI4-Lite register bus and a 10 MHz system clock
package usart_pkg;
    // register byte offsets
    localparam logic [7:0] OFF_CTRL      = 8'h00;
    localparam logic [7:0] OFF_BAUD_LOW  = 8'h04;
    localparam logic [7:0] OFF_BAUD_HIGH = 8'h08;
    localparam logic [7:0] OFF_DATA      = 8'h0C;
    localparam logic [7:0] OFF_STATUS    = 8'h10;

    // control register fields
    localparam int CTRL_W         = 7;
    localparam int CTRL_PWR_BIT   = 0;
    localparam int CTRL_SYNC_BIT  = 1;
    localparam int CTRL_DBL_BIT   = 2;
    localparam int CTRL_DIR_BIT   = 3;
    localparam int CTRL_POL_BIT   = 4;
    localparam int CTRL_CSZ2_BIT  = 5;
    localparam int CTRL_TX9_BIT   = 6;
    localparam logic [6:0] CTRL_RESET = 7'h01;

    // status register fields
    localparam int STAT_RXAVAIL_BIT = 0;
    localparam int STAT_FE_BIT      = 1;
    localparam int STAT_OVR_BIT     = 2;
    localparam int STAT_PERR_BIT    = 3;
    localparam int STAT_RX9_BIT     = 4;
    localparam int STAT_TXEMPTY_BIT = 5;

    // baud divisor
    localparam int BAUD_W           = 12;
    localparam logic [3:0]  BAUD_HIGH_RESET = 4'h0;
    localparam logic [7:0]  BAUD_LOW_RESET  = 8'h00;

    // transmit divide ratios, held as ratio minus one
    localparam logic [3:0] DIV_NORMAL_M1 = 4'hF;
    localparam logic [3:0] DIV_DOUBLE_M1 = 4'h7;
    localparam logic [3:0] DIV_SYNC_M1   = 4'h1;

    // receive entry: {parity err, overrun, frame err, ninth bit, data}
    localparam int RX_ENTRY_W = 12;
    localparam int RX_DEPTH   = 2;

    // bus responses
    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

// [src/usart_clkgen_rxbuf.sv]
// serial clock generation, transmit write buffer and receive buffering
// assumes an external shift/frame engine using the strobes and buffers
// here; registers reached over AXI4-Lite; one 10 MHz clock
// Operation
// - power reduce bit set keeps module idle
// - one pending transmit character beside shift register
// - two-entry circular receive queue, read pops one
// - error flags, ninth bit stored per entry
// - full queue: character waits in shift register
// - four clock modes, mode bit picks sync
// - sync: pin direction picks master or slave
// - transfer clock pin unused in async modes
// - counter reloads at zero and low write
// - one tick per zero, clock over divisor+1
// - transmit divides tick by 16, 8, 2
// - twelve-bit divisor split high and low
// - double speed halves divider and samples
// - slave clock synchronised, edge detected, two cycles
// - receiver reports frame, overrun, parity errors
// - polarity bit swaps change and sample edges
//
// Our own choices: the AXI4-Lite interface to the registers and the placing of the registers.
`timescale 1ns/1ps
module usart_clkgen_rxbuf (
    input  wire logic        aclk,
    input  wire logic        aresetn,
    input  wire logic [7:0]  awaddr,
    input  wire logic        awvalid,
    output logic             awready,
    input  wire logic [31:0] wdata,
    input  wire logic [3:0]  wstrb,
    input  wire logic        wvalid,
    output logic             wready,
    output logic [1:0]       bresp,
    output logic             bvalid,
    input  wire logic        bready,
    input  wire logic [7:0]  araddr,
    input  wire logic        arvalid,
    output logic             arready,
    output logic [31:0]      rdata,
    output logic [1:0]       rresp,
    output logic             rvalid,
    input  wire logic        rready,
    input  wire logic        xck_in,
    output logic             xck_out,
    output logic             xck_oe,
    output logic [8:0]       tx_data,
    output logic             tx_valid,
    input  wire logic        tx_ready,
    output logic             tx_shift_en,
    output logic             rx_sample_en,
    output logic [4:0]       rx_states_per_bit,
    output logic             char_size_bit2,
    input  wire logic        rx_start_seen,
    input  wire logic        rx_done,
    input  wire logic [8:0]  rx_char,
    input  wire logic        rx_frame_err,
    input  wire logic        rx_parity_err
);
    logic [6:0]  ctrl_q;
    logic [3:0]  baud_high_q;
    logic [7:0]  baud_low_q;
    logic [11:0] cnt_q;
    logic [3:0]  txdiv_q;
    logic        xck_int_q;
    logic        xs1_q;
    logic        xs2_q;
    logic        xprev_q;
    logic        txb_v_q;
    logic [8:0]  txb_q;
    logic        hold_v_q;
    logic [10:0] hold_q;
    logic        ovr_pend_q;
    logic        bvalid_q;
    logic [1:0]  bresp_q;
    logic        rvalid_q;
    logic [31:0] rdata_q;
    logic [1:0]  rresp_q;

    // register bus decode
    wire wr_go    = awvalid & wvalid & ~bvalid_q;
    wire wr_lane0 = wr_go & wstrb[0];
    wire wr_ctrl  = wr_lane0 & (awaddr == usart_pkg::OFF_CTRL);
    wire wr_low   = wr_lane0 & (awaddr == usart_pkg::OFF_BAUD_LOW);
    wire wr_high  = wr_lane0 & (awaddr == usart_pkg::OFF_BAUD_HIGH);
    wire wr_data  = wr_go & (wstrb[1:0] != 2'h0) & (awaddr == usart_pkg::OFF_DATA);
    wire wr_hit   = (awaddr == usart_pkg::OFF_CTRL) | (awaddr == usart_pkg::OFF_BAUD_LOW)
                  | (awaddr == usart_pkg::OFF_BAUD_HIGH) | (awaddr == usart_pkg::OFF_DATA)
                  | (awaddr == usart_pkg::OFF_STATUS);
    wire rd_go    = arvalid & ~rvalid_q;
    wire rd_hit   = (araddr == usart_pkg::OFF_CTRL) | (araddr == usart_pkg::OFF_BAUD_LOW)
                  | (araddr == usart_pkg::OFF_BAUD_HIGH) | (araddr == usart_pkg::OFF_DATA)
                  | (araddr == usart_pkg::OFF_STATUS);

    assign awready = wr_go;
    assign wready  = wr_go;
    assign arready = rd_go;
    assign bvalid  = bvalid_q;
    assign bresp   = bresp_q;
    assign rvalid  = rvalid_q;
    assign rdata   = rdata_q;
    assign rresp   = rresp_q;

    // mode decode
    wire enabled  = ~ctrl_q[usart_pkg::CTRL_PWR_BIT];
    wire sync_w   = ctrl_q[usart_pkg::CTRL_SYNC_BIT];
    wire master_w = sync_w & ctrl_q[usart_pkg::CTRL_DIR_BIT];
    wire slave_w  = sync_w & ~ctrl_q[usart_pkg::CTRL_DIR_BIT];
    // double speed is masked in sync modes rather than trusted to software
    wire dbl_w    = ctrl_q[usart_pkg::CTRL_DBL_BIT] & ~sync_w;
    wire pol_w    = ctrl_q[usart_pkg::CTRL_POL_BIT];
    wire [11:0] divisor_w = {baud_high_q, baud_low_q};

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            ctrl_q <= usart_pkg::CTRL_RESET;
        else if (wr_ctrl)
            ctrl_q <= wdata[6:0];
    end

    // high byte only stored; it reaches the counter at the next reload
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            baud_high_q <= usart_pkg::BAUD_HIGH_RESET;
            baud_low_q  <= usart_pkg::BAUD_LOW_RESET;
        end
        else
        begin
            if (wr_high)
                baud_high_q <= wdata[3:0];
            if (wr_low)
                baud_low_q <= wdata[7:0];
        end
    end

    // baud down-counter
    wire baud_tick = enabled & (cnt_q == 12'h000);
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            cnt_q <= 12'h000;
        else if (wr_low)
            cnt_q <= {baud_high_q, wdata[7:0]};
        else if (!enabled || cnt_q == 12'h000)
            cnt_q <= divisor_w;
        else
            cnt_q <= cnt_q - 12'h001;
    end

    // transmit divide ratio and receive states per bit
    wire [3:0] div_m1_w = sync_w ? usart_pkg::DIV_SYNC_M1
                        : dbl_w ? usart_pkg::DIV_DOUBLE_M1
                        : usart_pkg::DIV_NORMAL_M1;
    assign rx_states_per_bit = 5'(div_m1_w) + 5'h01;
    wire tx_tick_async = baud_tick & (txdiv_q >= div_m1_w);

    always_ff @(posedge aclk)
    begin
        if (!aresetn || !enabled)
            txdiv_q <= 4'h0;
        else if (tx_tick_async)
            txdiv_q <= 4'h0;
        else if (baud_tick)
            txdiv_q <= txdiv_q + 4'h1;
    end

    // master clock: toggling on each tick gives the divide by two
    always_ff @(posedge aclk)
    begin
        if (!aresetn || !master_w || !enabled)
            xck_int_q <= pol_w;
        else if (baud_tick)
            xck_int_q <= ~xck_int_q;
    end

    // slave clock: two-stage synchroniser, then edge detector
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            xs1_q   <= 1'b0;
            xs2_q   <= 1'b0;
            xprev_q <= 1'b0;
        end
        else
        begin
            xs1_q   <= xck_in;
            xs2_q   <= xs1_q;
            xprev_q <= xs2_q;
        end
    end

    wire clk_rise = master_w ? (baud_tick & ~xck_int_q) : (xs2_q & ~xprev_q);
    wire clk_fall = master_w ? (baud_tick & xck_int_q) : (~xs2_q & xprev_q);
    wire chg_edge = pol_w ? clk_fall : clk_rise;
    wire smp_edge = pol_w ? clk_rise : clk_fall;

    // the pin only matters once sync mode is chosen
    assign tx_shift_en  = enabled & (sync_w ? chg_edge : tx_tick_async);
    assign rx_sample_en = enabled & (sync_w ? smp_edge : baud_tick);
    assign xck_out      = xck_int_q;
    assign xck_oe       = enabled & master_w;
    assign char_size_bit2 = ctrl_q[usart_pkg::CTRL_CSZ2_BIT];

    // transmit write buffer
    assign tx_valid = enabled & txb_v_q;
    assign tx_data  = txb_q;
    always_ff @(posedge aclk)
    begin
        if (!aresetn || !enabled)
            txb_v_q <= 1'b0;
        else if (wr_data && !txb_v_q)
            txb_v_q <= 1'b1;
        else if (tx_valid && tx_ready)
            txb_v_q <= 1'b0;
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            txb_q <= 9'h000;
        else if (wr_data && !txb_v_q)
            txb_q <= {ctrl_q[usart_pkg::CTRL_TX9_BIT], wdata[7:0]};
    end

    // receive path: shift-register level, then the queue
    logic                  fifo_in_ready;
    logic [11:0]           head_w;
    logic                  head_valid;
    logic [1:0]            rx_level;
    wire rd_data = rd_go & (araddr == usart_pkg::OFF_DATA);
    wire pop     = rd_data & head_valid;
    wire push    = hold_v_q & fifo_in_ready;
    // a new start bit with nowhere to go discards the waiting character
    wire lost    = enabled & rx_start_seen & hold_v_q & ~fifo_in_ready;

    always_ff @(posedge aclk)
    begin
        if (!aresetn || !enabled)
            hold_v_q <= 1'b0;
        else if (rx_done)
            hold_v_q <= 1'b1;
        else if (push || lost)
            hold_v_q <= 1'b0;
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            hold_q <= 11'h000;
        else if (rx_done)
            hold_q <= {rx_parity_err, rx_frame_err, rx_char};
    end

    // set wins: the next pushed entry carries the overrun
    always_ff @(posedge aclk)
    begin
        if (!aresetn || !enabled)
            ovr_pend_q <= 1'b0;
        else if (lost)
            ovr_pend_q <= 1'b1;
        else if (push)
            ovr_pend_q <= 1'b0;
    end

    usart_fifo #(
        .WIDTH (usart_pkg::RX_ENTRY_W),
        .DEPTH (usart_pkg::RX_DEPTH)
    ) u_rx_fifo (
        .aclk      (aclk),
        .aresetn   (aresetn),
        .flush     (~enabled),
        .in_data   ({hold_q[10], ovr_pend_q, hold_q[9:0]}),
        .in_valid  (hold_v_q),
        .in_ready  (fifo_in_ready),
        .out_data  (head_w),
        .out_valid (head_valid),
        .out_ready (pop),
        .level     (rx_level)
    );

    // status shows the head entry, read before the data pops it
    wire [31:0] status_w = {26'h0, ~txb_v_q, {4{head_valid}} & {head_w[8], head_w[11],
                            head_w[10], head_w[9]}, head_valid};
    wire [31:0] rd_mux =
        (araddr == usart_pkg::OFF_CTRL)      ? {25'h0, ctrl_q} :
        (araddr == usart_pkg::OFF_BAUD_LOW)  ? {24'h0, baud_low_q} :
        (araddr == usart_pkg::OFF_BAUD_HIGH) ? {28'h0, baud_high_q} :
        (araddr == usart_pkg::OFF_DATA)      ? {24'h0, head_w[7:0]} :
        (araddr == usart_pkg::OFF_STATUS)    ? status_w : 32'h0;

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            bvalid_q <= 1'b0;
            bresp_q  <= usart_pkg::RESP_OKAY;
        end
        else if (wr_go)
        begin
            bvalid_q <= 1'b1;
            bresp_q  <= wr_hit ? usart_pkg::RESP_OKAY : usart_pkg::RESP_SLVERR;
        end
        else if (bready)
            bvalid_q <= 1'b0;
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            rvalid_q <= 1'b0;
            rdata_q  <= 32'h0;
            rresp_q  <= usart_pkg::RESP_OKAY;
        end
        else if (rd_go)
        begin
            rvalid_q <= 1'b1;
            rdata_q  <= rd_mux;
            rresp_q  <= rd_hit ? usart_pkg::RESP_OKAY : usart_pkg::RESP_SLVERR;
        end
        else if (rready)
            rvalid_q <= 1'b0;
    end

    // checks
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    sequence s_quiet4;
        (!wr_low && !wr_high && enabled)[*4];
    endsequence

    sequence s_slave_high;
        (slave_w && enabled && !pol_w && xck_in)[*3];
    endsequence

    sequence s_slave_low;
        (slave_w && enabled && !pol_w && !xck_in)[*3];
    endsequence

    a_power_idle:
    assert property (!enabled |-> !tx_shift_en && !rx_sample_en && !xck_oe && !tx_valid)
        else $error("module active while power reduce bit set");

    a_zero_reload:
    assert property (cnt_q == 12'h000 && !wr_low |=> cnt_q == $past(divisor_w))
        else $error("counter did not reload divisor at zero");

    a_low_reload:
    assert property (wr_low |=> cnt_q == {$past(baud_high_q), $past(wdata[7:0])})
        else $error("low write did not reload counter at once");

    a_high_deferred:
    assert property (wr_high && !wr_low && enabled && cnt_q != 12'h000
                     |=> cnt_q == $past(cnt_q) - 12'h001)
        else $error("high write disturbed running counter");

    a_tick_period:
    assert property (baud_tick && !wr_low && divisor_w == 12'h003 ##1 s_quiet4 |-> baud_tick)
        else $error("tick period not divisor plus one");

    a_slave_latency:
    assert property (s_slave_high ##1 s_slave_low |-> rx_sample_en)
        else $error("slave sample edge not two cycles after pin");

    a_pin_role:
    assert property (enabled && !sync_w |-> !xck_oe && rx_sample_en == baud_tick)
        else $error("transfer clock pin used in async mode");

    a_tx_pending:
    assert property (wr_data && !txb_v_q && enabled && !wr_ctrl |=> tx_valid)
        else $error("written character not pending for transmit");

    a_third_level:
    assert property (enabled && hold_v_q && !fifo_in_ready && !rx_start_seen && !rx_done
                     |=> hold_v_q && $stable(hold_q))
        else $error("waiting character lost without start bit");

    a_pop_one:
    assert property (pop && !push && rx_level == 2'h2 |=> rx_level == 2'h1)
        else $error("data read did not consume exactly one entry");

    a_overrun_mark:
    assert property (lost ##1 push |-> u_rx_fifo.in_data[10])
        else $error("overrun not carried by next entry");

    a_normal_div:
    assert property (enabled && !sync_w && !dbl_w && tx_shift_en
                     |-> txdiv_q == usart_pkg::DIV_NORMAL_M1 && rx_states_per_bit == 5'h10)
        else $error("normal mode divide not sixteen");
endmodule

// [src/usart_fifo.sv]
// small first-in first-out queue held in flip-flops
// assumes one clock, synchronous active-low reset, flush clears contents
`timescale 1ns/1ps
module usart_fifo #(
    parameter int WIDTH = 12,
    parameter int DEPTH = 2
) (
    input  wire logic                       aclk,
    input  wire logic                       aresetn,
    input  wire logic                       flush,
    input  wire logic [WIDTH-1:0]           in_data,
    input  wire logic                       in_valid,
    output logic                            in_ready,
    output logic [WIDTH-1:0]                out_data,
    output logic                            out_valid,
    input  wire logic                       out_ready,
    output logic [$clog2(DEPTH+1)-1:0]      level
);
    localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
    localparam int CW = $clog2(DEPTH+1);

    logic [WIDTH-1:0] mem_q [DEPTH];
    logic [AW-1:0]    wptr_q;
    logic [AW-1:0]    rptr_q;
    logic [CW-1:0]    cnt_q;
    logic             do_push;
    logic             do_pop;

    assign in_ready  = (cnt_q != CW'(DEPTH));
    assign out_valid = (cnt_q != '0);
    assign out_data  = mem_q[rptr_q];
    assign level     = cnt_q;
    assign do_push   = in_valid & in_ready;
    assign do_pop    = out_valid & out_ready;

    // circular pointers wrap at the depth
    always_ff @(posedge aclk)
    begin
        if (!aresetn || flush)
        begin
            wptr_q <= '0;
            rptr_q <= '0;
            cnt_q  <= '0;
        end
        else
        begin
            if (do_push)
                wptr_q <= (wptr_q == AW'(DEPTH-1)) ? '0 : wptr_q + 1'b1;
            if (do_pop)
                rptr_q <= (rptr_q == AW'(DEPTH-1)) ? '0 : rptr_q + 1'b1;
            cnt_q <= cnt_q + CW'(do_push) - CW'(do_pop);
        end
    end

    always_ff @(posedge aclk)
    begin
        if (do_push)
            mem_q[wptr_q] <= in_data;
    end
endmodule

// [test/tb_usart_clkgen_rxbuf.sv]
// self-checking bench for the clock generator and buffers
// assumes the peer model stands at the shift engine side
`timescale 1ns/1ps
module tb_usart_clkgen_rxbuf;
    logic        aclk;
    logic        aresetn;
    logic [7:0]  awaddr;
    logic        awvalid;
    logic        awready;
    logic [31:0] wdata;
    logic        wvalid;
    logic        wready;
    logic [1:0]  bresp;
    logic        bvalid;
    logic        bready;
    logic [7:0]  araddr;
    logic        arvalid;
    logic        arready;
    logic [31:0] rdata;
    logic [1:0]  rresp;
    logic        rvalid;
    logic        rready;
    logic        xck_in;
    logic        xck_out;
    logic        xck_oe;
    logic [8:0]  tx_data;
    logic        tx_valid;
    logic        tx_ready;
    logic        tx_shift_en;
    logic        rx_sample_en;
    logic [4:0]  rx_states_per_bit;
    logic        rx_start_seen;
    logic        rx_done;
    logic [8:0]  rx_char;
    logic        rx_frame_err;
    logic        rx_parity_err;
    logic        csz2;
    int          error_cnt;
    int          num_checks;
    logic [31:0] d;

    usart_clkgen_rxbuf u_usart_clkgen_rxbuf (.aclk(aclk), .aresetn(aresetn),
        .awaddr(awaddr), .awvalid(awvalid), .awready(awready), .wdata(wdata),
        .wstrb(4'hF), .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid),
        .bready(bready), .araddr(araddr), .arvalid(arvalid), .arready(arready),
        .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
        .xck_in(xck_in), .xck_out(xck_out), .xck_oe(xck_oe), .tx_data(tx_data),
        .tx_valid(tx_valid), .tx_ready(tx_ready), .tx_shift_en(tx_shift_en),
        .rx_sample_en(rx_sample_en), .rx_states_per_bit(rx_states_per_bit),
        .char_size_bit2(csz2), .rx_start_seen(rx_start_seen), .rx_done(rx_done),
        .rx_char(rx_char), .rx_frame_err(rx_frame_err), .rx_parity_err(rx_parity_err));
    usart_peer u_usart_peer (.aclk(aclk), .tx_data(tx_data), .tx_valid(tx_valid),
        .tx_ready(tx_ready), .rx_start_seen(rx_start_seen), .rx_done(rx_done),
        .rx_char(rx_char), .rx_frame_err(rx_frame_err), .rx_parity_err(rx_parity_err),
        .xck_in(xck_in));

    initial
    begin
        aclk = 1'b0;
        forever #50 aclk = ~aclk;
    end

    task report_and_stop();
        $display("checks %0d mismatches %0d", num_checks, error_cnt);
        if (error_cnt == 0 && num_checks > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp)
        begin
            error_cnt++;
            $display("wrong value at %0t: got %0h expected %0h", $time, got, exp);
        end
    endtask

    task automatic give_up(input int n);
        if (n >= 200)
        begin
            error_cnt++;
            report_and_stop();
        end
    endtask

    // write: address and data offered together, held until taken
    task automatic axi_wr(input logic [7:0] a, input logic [31:0] v, input logic [1:0] er);
        int n;
        n = 0;
        @(posedge aclk);
        awaddr <= a;
        wdata <= v;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        do begin @(negedge aclk); n++; end while (!(awready && wready) && n < 200);
        @(posedge aclk);
        awvalid <= 1'b0;
        wvalid <= 1'b0;
        while (!bvalid && n < 200) begin @(negedge aclk); n++; end
        give_up(n);
        chk(32'(bresp), 32'(er));
        @(posedge aclk);
        bready <= 1'b0;
    endtask

    task automatic axi_rd(input logic [7:0] a, output logic [31:0] v, input logic [1:0] er);
        int n;
        n = 0;
        @(posedge aclk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do begin @(negedge aclk); n++; end while (!arready && n < 200);
        @(posedge aclk);
        arvalid <= 1'b0;
        while (!rvalid && n < 200) begin @(negedge aclk); n++; end
        give_up(n);
        v = rdata;
        chk(32'(rresp), 32'(er));
        @(posedge aclk);
        rready <= 1'b0;
    endtask

    task automatic count(input int cyc, output int nr, output int nt, output int ng);
        logic last;
        nr = 0;
        nt = 0;
        ng = 0;
        last = xck_out;
        repeat (cyc)
        begin
            @(negedge aclk);
            nr += int'(rx_sample_en);
            nt += int'(tx_shift_en);
            ng += int'(xck_out != last);
            last = xck_out;
        end
    endtask

    task automatic rd_entry(input logic [31:0] st, input logic [31:0] dat);
        axi_rd(usart_pkg::OFF_STATUS, d, usart_pkg::RESP_OKAY);
        chk(d & 32'h0000001F, st);
        axi_rd(usart_pkg::OFF_DATA, d, usart_pkg::RESP_OKAY);
        chk(d, dat);
    endtask

    task automatic t_regs();
        axi_rd(usart_pkg::OFF_CTRL, d, usart_pkg::RESP_OKAY);
        chk(d, 32'h00000001);
        axi_rd(usart_pkg::OFF_BAUD_HIGH, d, usart_pkg::RESP_OKAY);
        chk(d, 32'h00000000);
        axi_rd(usart_pkg::OFF_STATUS, d, usart_pkg::RESP_OKAY);
        chk(d, 32'h00000020);
        axi_rd(8'h20, d, usart_pkg::RESP_SLVERR);
        chk(d, 32'h00000000);
        axi_wr(8'h20, 32'h000000FF, usart_pkg::RESP_SLVERR);
        $display("test registers done");
    endtask

    task automatic t_modes();
        logic [6:0] mc [7];
        int er [7];
        int et [7];
        int eg [7];
        int es [7];
        int nr, nt, ng;
        mc = '{7'h01, 7'h00, 7'h04, 7'h08, 7'h0A, 7'h2A, 7'h1A};
        er = '{0, 160, 160, 160, 80, 80, 80};
        et = '{0, 10, 20, 10, 80, 80, 80};
        eg = '{0, 0, 0, 0, 160, 160, 160};
        es = '{16, 16, 8, 16, 2, 2, 2};
        axi_wr(usart_pkg::OFF_BAUD_LOW, 32'h00000003, usart_pkg::RESP_OKAY);
        for (int i = 0; i < 7; i++)
        begin
            axi_wr(usart_pkg::OFF_CTRL, {25'h0, mc[i]}, usart_pkg::RESP_OKAY);
            repeat (16) @(posedge aclk);
            count(640, nr, nt, ng);
            chk(32'(nr), 32'(er[i]));
            chk(32'(nt), 32'(et[i]));
            chk(32'(ng), 32'(eg[i]));
            chk(32'(rx_states_per_bit), 32'(es[i]));
            chk(32'(xck_oe), 32'(i > 3));
            chk(32'(csz2), 32'(mc[i][5]));
        end
        // high byte alone waits for the next reload at zero
        axi_wr(usart_pkg::OFF_CTRL, 32'h00000000, usart_pkg::RESP_OKAY);
        axi_wr(usart_pkg::OFF_BAUD_HIGH, 32'h00000001, usart_pkg::RESP_OKAY);
        repeat (300) @(posedge aclk);
        count(2600, nr, nt, ng);
        chk(32'(nr), 32'd10);
        axi_wr(usart_pkg::OFF_BAUD_HIGH, 32'h00000000, usart_pkg::RESP_OKAY);
        axi_wr(usart_pkg::OFF_BAUD_LOW, 32'h00000003, usart_pkg::RESP_OKAY);
        count(40, nr, nt, ng);
        chk(32'(nr), 32'd10);
        $display("test clock modes done");
    endtask

    task automatic t_slave();
        int nr, nt, ng;
        axi_wr(usart_pkg::OFF_CTRL, 32'h00000002, usart_pkg::RESP_OKAY);
        repeat (8) @(posedge aclk);
        fork
            u_usart_peer.run_xck(10);
            count(90, nr, nt, ng);
        join
        chk(32'(nr), 32'd10);
        chk(32'(nt), 32'd10);
        chk(32'(xck_oe), 32'd0);
        $display("test slave clock done");
    endtask

    task automatic t_rx();
        axi_wr(usart_pkg::OFF_CTRL, 32'h00000000, usart_pkg::RESP_OKAY);
        u_usart_peer.push(9'h041, 1'b1, 1'b0);
        u_usart_peer.push(9'h142, 1'b0, 1'b0);
        u_usart_peer.push(9'h043, 1'b0, 1'b1);
        repeat (4) @(posedge aclk);
        rd_entry(32'h03, 32'h41);
        rd_entry(32'h11, 32'h42);
        rd_entry(32'h09, 32'h43);
        rd_entry(32'h00, 32'h42);
        u_usart_peer.push(9'h044, 1'b0, 1'b0);
        u_usart_peer.push(9'h045, 1'b0, 1'b0);
        u_usart_peer.push(9'h046, 1'b0, 1'b0);
        u_usart_peer.start_bit();
        u_usart_peer.push(9'h047, 1'b0, 1'b0);
        rd_entry(32'h01, 32'h44);
        rd_entry(32'h01, 32'h45);
        rd_entry(32'h05, 32'h47);
        // power reduction drops whatever is queued
        u_usart_peer.push(9'h048, 1'b0, 1'b0);
        axi_wr(usart_pkg::OFF_CTRL, 32'h00000001, usart_pkg::RESP_OKAY);
        axi_rd(usart_pkg::OFF_STATUS, d, usart_pkg::RESP_OKAY);
        chk(d & 32'h00000001, 32'h0);
        $display("test receive queue done");
    endtask

    task automatic t_tx();
        axi_wr(usart_pkg::OFF_CTRL, 32'h00000040, usart_pkg::RESP_OKAY);
        axi_wr(usart_pkg::OFF_DATA, 32'h0000005A, usart_pkg::RESP_OKAY);
        axi_wr(usart_pkg::OFF_DATA, 32'h000000A5, usart_pkg::RESP_OKAY);
        axi_rd(usart_pkg::OFF_STATUS, d, usart_pkg::RESP_OKAY);
        chk(d & 32'h00000020, 32'h0);
        chk(32'(tx_data), 32'h15A);
        @(posedge aclk);
        u_usart_peer.stall <= 1'b0;
        repeat (4) @(posedge aclk);
        chk(32'(u_usart_peer.got_q), 32'h15A);
        axi_rd(usart_pkg::OFF_STATUS, d, usart_pkg::RESP_OKAY);
        chk(d & 32'h00000020, 32'h20);
        $display("test transmit buffer done");
    endtask

    initial
    begin
        error_cnt = 0;
        num_checks = 0;
        aresetn = 1'b0;
        awaddr = 8'h00;
        awvalid = 1'b0;
        wdata = 32'h00000000;
        wvalid = 1'b0;
        bready = 1'b0;
        araddr = 8'h00;
        arvalid = 1'b0;
        rready = 1'b0;
        repeat (12) @(posedge aclk);
        aresetn <= 1'b1;
        t_regs();
        t_modes();
        t_slave();
        t_rx();
        t_tx();
        report_and_stop();
    end
endmodule

// [test/usart_peer.sv]
// remote peer model: shift engine and serial partner beside the buffers
// assumes the bench calls its tasks; signals change just after rising aclk
`timescale 1ns/1ps
module usart_peer (
    input  wire logic       aclk,
    input  wire logic [8:0] tx_data,
    input  wire logic       tx_valid,
    output logic            tx_ready,
    output logic            rx_start_seen,
    output logic            rx_done,
    output logic [8:0]      rx_char,
    output logic            rx_frame_err,
    output logic            rx_parity_err,
    output logic            xck_in
);
    logic       stall;
    logic [8:0] got_q;
    initial
    begin
        stall = 1'b1;
        got_q = 9'h000;
        rx_start_seen = 1'b0;
        rx_done = 1'b0;
        rx_char = 9'h000;
        rx_frame_err = 1'b0;
        rx_parity_err = 1'b0;
        xck_in = 1'b0;
    end
    assign tx_ready = ~stall;
    always @(posedge aclk)
        if (tx_valid && tx_ready)
            got_q <= tx_data;
    // character and flags arrive with the done pulse
    task automatic push(input logic [8:0] c, input logic fe, input logic pe);
        @(posedge aclk);
        rx_done <= 1'b1;
        rx_char <= c;
        rx_frame_err <= fe;
        rx_parity_err <= pe;
        @(posedge aclk);
        rx_done <= 1'b0;
        // stale lines show garbage
        rx_char <= ~c;
        rx_frame_err <= ~fe;
        rx_parity_err <= ~pe;
    endtask
    task automatic start_bit();
        @(posedge aclk);
        rx_start_seen <= 1'b1;
        @(posedge aclk);
        rx_start_seen <= 1'b0;
    endtask
    // period of 8 cycles, under a quarter of aclk; idles low
    task automatic run_xck(input int n);
        repeat (2 * n)
        begin
            @(posedge aclk);
            xck_in <= ~xck_in;
            repeat (3) @(posedge aclk);
        end
    endtask
endmodule
